// ### rtl/mso_cfg.sv
// Mask option and software option configuration block of the controller
`timescale 1ns/1ps
`default_nettype none
`include "mso_regs.svh"

module mso_cfg
    import mso_pkg::*;
#(
    parameter int          PB_WIDTH      = 8,
    parameter int          PD_WIDTH      = 7,
    parameter int          SPI_PINS      = 3,
    parameter logic        BASE_STOP_EN  = 1'b1,
    parameter logic        BASE_WDOG_EN  = 1'b0
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Classic Wishbone register port
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [15:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic                     ack_o,
    output logic [31:0]              dat_o,
    // Nonvolatile option locations
    input  wire logic [PB_WIDTH-1:0] port_b_option_location_i,
    input  wire logic [7:0]          personality_option_location_i,
    // Port B
    input  wire logic [PB_WIDTH-1:0] port_b_ddr_i,
    output logic [PB_WIDTH-1:0]      port_b_pullup_interrupt_enables_o,
    // Port D and SPI pins
    input  wire logic [PD_WIDTH-1:0] port_d_ddr_i,
    output logic [PD_WIDTH-1:0]      port_d_out_en_o,
    input  wire logic                port_d_wire_or_i,
    output logic                     port_d_open_drain_o,
    input  wire logic [SPI_PINS-1:0] spi_drive_req_i,
    input  wire logic [SPI_PINS-1:0] spi_ddr_i,
    output logic [SPI_PINS-1:0]      spi_out_en_o,
    // Reset pin
    input  wire logic                int_reset_req_i,
    output logic                     reset_pin_o,
    output logic                     reset_pin_oe_o,
    // Core options
    output logic                     irq_edge_level_o,
    output logic                     stop_en_o,
    output logic                     wdog_en_o,
    output logic                     compat_mode_o,
    // Memory decoder
    input  wire logic [15:0]         cpu_addr_i,
    output logic                     ram_select_o,
    output logic                     eprom_select_o
);

    // Option location synchronisers and latched copies
    logic [PB_WIDTH-1:0] pb_meta_r;
    logic [PB_WIDTH-1:0] pb_sync_r;
    logic [7:0]          pers_meta_r;
    logic [7:0]          pers_sync_r;
    logic [PB_WIDTH-1:0] pb_opt_r;
    mso_pers_t           pers_r;
    logic                compat;

    // Software option state
    mso_sw_opt_t         sw_r;
    mso_sw_opt_t         sw_nxt;
    logic                irq_lock_r;
    mso_sw_opt_t         sw_eff;

    // Bus side
    logic                wr_en;
    logic [7:0]          wr_byte;
    logic                rd_latch;
    logic [7:0]          rd_byte;

    // Effective options
    logic                irq_level_eff;

    // Pin output registers
    logic [PB_WIDTH-1:0] pb_en_r;
    logic [PD_WIDTH-1:0] pd_oe_r;
    logic                pd_od_r;
    logic [SPI_PINS-1:0] spi_oe_r;
    logic                rst_oe_r;
    logic                irq_r;
    logic                stop_r;
    logic                wdog_r;

    // Memory decode
    logic                low_hit;
    logic                low_ram;
    logic                high_hit;
    logic                high_ram;
    logic                ram_r;
    logic                eprom_r;

    // Option locations are not in this clock domain; sync before use
    always_ff @(posedge clk_i)
    begin
        pb_meta_r   <= port_b_option_location_i;
        pb_sync_r   <= pb_meta_r;
        pers_meta_r <= personality_option_location_i;
        pers_sync_r <= pers_meta_r;
    end

    // Options are taken while reset is held, so software cannot
    // change the personality while running; the array must be
    // programmed before the part runs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pb_opt_r <= pb_sync_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pers_r.mode      <= pers_sync_r[`MSO_PERS_COMPAT_BIT]
                                ? MSO_MODE_COMPAT : MSO_MODE_BASE;
            pers_r.stop_en   <= pers_sync_r[`MSO_PERS_STOP_BIT];
            pers_r.wdog_en   <= pers_sync_r[`MSO_PERS_WDOG_BIT];
            pers_r.irq_level <= pers_sync_r[`MSO_PERS_IRQ_BIT];
        end
    end

    assign compat = (pers_r.mode == MSO_MODE_COMPAT);

    mso_wb_slave u_wb
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cyc_i      (cyc_i),
        .stb_i      (stb_i),
        .we_i       (we_i),
        .sel_i      (sel_i),
        .dat_i      (dat_i),
        .rd_byte_i  (rd_byte),
        .ack_o      (ack_o),
        .dat_o      (dat_o),
        .wr_en_o    (wr_en),
        .wr_byte_o  (wr_byte),
        .rd_latch_o (rd_latch)
    );

    // Software option next value; the register is blind to writes
    // outside base mode, and the sensitivity bit only takes the
    // first write after reset
    always_comb
    begin
        sw_nxt = sw_r;
        if (wr_en && (adr_i == `MSO_ADR_SW_OPT) && !compat)
        begin
            sw_nxt.low_map  = wr_byte[`MSO_SW_LOW_BIT];
            sw_nxt.high_map = wr_byte[`MSO_SW_HIGH_BIT];
            if (!irq_lock_r)
                sw_nxt.irq_level = wr_byte[`MSO_SW_IRQ_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sw_r <= mso_sw_opt_t'(`MSO_SW_OPT_RESET);
        else
            sw_r <= sw_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_lock_r <= 1'b0;
        else if (wr_en && (adr_i == `MSO_ADR_SW_OPT) && !compat)
            irq_lock_r <= 1'b1;
    end

    // In compatibility mode the windows fall back to EPROM
    always_comb
    begin
        sw_eff = sw_r;
        if (compat)
        begin
            sw_eff.low_map  = 1'b0;
            sw_eff.high_map = 1'b0;
        end
    end

    // One sensitivity feeds the external pin and all port B pins
    assign irq_level_eff = compat ? pers_r.irq_level
                                  : sw_r.irq_level;

    // Register read mux; unmapped addresses read zero
    always_comb
    begin
        case (adr_i)
            `MSO_ADR_PB_OPT:
                rd_byte = 8'(pb_opt_r);
            `MSO_ADR_SW_OPT:
                rd_byte = compat ? 8'h00 : 8'(sw_r);
            `MSO_ADR_PERS_OPT:
                rd_byte = 8'(pers_r);
            `MSO_ADR_STATUS:
            begin
                rd_byte = 8'h00;
                rd_byte[`MSO_ST_COMPAT_BIT]   = compat;
                rd_byte[`MSO_ST_IRQ_LOCK_BIT] = irq_lock_r;
            end
            default:
                rd_byte = 8'h00;
        endcase
    end

    // Port B pullup and interrupt enable, only while pin is an input
    genvar gi;
    generate
        for (gi = 0; gi < PB_WIDTH; gi = gi + 1)
        begin : g_pb
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    pb_en_r[gi] <= 1'b0;
                else
                    pb_en_r[gi] <= pb_opt_r[gi] & ~port_b_ddr_i[gi];
            end
        end
    endgenerate

    // Port D direction: the direction register is ignored in
    // compatibility mode, so the pins can only be inputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pd_oe_r <= '0;
        else if (compat)
            pd_oe_r <= '0;
        else
            pd_oe_r <= port_d_ddr_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pd_od_r <= 1'b0;
        else
            pd_od_r <= port_d_wire_or_i & ~compat;
    end

    // SPI outputs drive straight from the SPI in compatibility mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            spi_oe_r <= '0;
        else if (compat)
            spi_oe_r <= spi_drive_req_i;
        else
            spi_oe_r <= spi_drive_req_i & spi_ddr_i;
    end

    // Reset pin pulldown only in base mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rst_oe_r <= 1'b0;
        else
            rst_oe_r <= int_reset_req_i & ~compat;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_r  <= 1'b1;
            stop_r <= 1'b0;
            wdog_r <= 1'b0;
        end
        else
        begin
            irq_r  <= irq_level_eff;
            stop_r <= compat ? pers_r.stop_en : BASE_STOP_EN;
            wdog_r <= compat ? pers_r.wdog_en : BASE_WDOG_EN;
        end
    end

    mso_win_dec
    #(
        .WIN_LO (`MSO_LOW_WIN_LO),
        .WIN_HI (`MSO_LOW_WIN_HI)
    )
    u_low_win
    (
        .addr_i    (cpu_addr_i),
        .map_ram_i (sw_eff.low_map),
        .hit_o     (low_hit),
        .ram_o     (low_ram)
    );

    mso_win_dec
    #(
        .WIN_LO (`MSO_HIGH_WIN_LO),
        .WIN_HI (`MSO_HIGH_WIN_HI)
    )
    u_high_win
    (
        .addr_i    (cpu_addr_i),
        .map_ram_i (sw_eff.high_map),
        .hit_o     (high_hit),
        .ram_o     (high_ram)
    );

    // Outside both windows neither select is asserted; the rest of
    // the memory map is decoded elsewhere
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ram_r   <= 1'b0;
            eprom_r <= 1'b0;
        end
        else
        begin
            ram_r   <= low_ram | high_ram;
            eprom_r <= (low_hit & ~low_ram) | (high_hit & ~high_ram);
        end
    end

    assign port_b_pullup_interrupt_enables_o = pb_en_r;
    assign port_d_out_en_o     = pd_oe_r;
    assign port_d_open_drain_o = pd_od_r;
    assign spi_out_en_o        = spi_oe_r;
    assign reset_pin_o         = 1'b0;
    assign reset_pin_oe_o      = rst_oe_r;
    assign irq_edge_level_o    = irq_r;
    assign stop_en_o           = stop_r;
    assign wdog_en_o           = wdog_r;
    assign compat_mode_o       = compat;
    assign ram_select_o        = ram_r;
    assign eprom_select_o      = eprom_r;

endmodule : mso_cfg

`default_nettype wire

// ### rtl/mso_regs.svh
// Register offsets, field positions, reset values and windows of option block
`ifndef MSO_REGS_SVH
`define MSO_REGS_SVH

`define MSO_ADR_PB_OPT      16'h3FF0
`define MSO_ADR_SW_OPT      16'h3FF4
`define MSO_ADR_PERS_OPT    16'h3FF8
`define MSO_ADR_STATUS      16'h3FFC

`define MSO_SW_LOW_BIT      0
`define MSO_SW_HIGH_BIT     1
`define MSO_SW_IRQ_BIT      2
`define MSO_SW_OPT_RESET    8'h04

`define MSO_PERS_COMPAT_BIT 0
`define MSO_PERS_STOP_BIT   1
`define MSO_PERS_WDOG_BIT   2
`define MSO_PERS_IRQ_BIT    3

`define MSO_ST_COMPAT_BIT   0
`define MSO_ST_IRQ_LOCK_BIT 1

`define MSO_LOW_WIN_LO      16'h0020
`define MSO_LOW_WIN_HI      16'h004F
`define MSO_HIGH_WIN_LO     16'h0100
`define MSO_HIGH_WIN_HI     16'h017F

`endif

// ### rtl/mso_pkg.sv
// Types shared by the option configuration block
package mso_pkg;

    typedef enum logic
    {
        MSO_MODE_BASE,
        MSO_MODE_COMPAT
    } mso_mode_t;

    typedef struct packed
    {
        logic irq_level;
        logic high_map;
        logic low_map;
    } mso_sw_opt_t;

    typedef struct packed
    {
        logic      irq_level;
        logic      wdog_en;
        logic      stop_en;
        mso_mode_t mode;
    } mso_pers_t;

endpackage : mso_pkg

// ### rtl/mso_wb_slave.sv
// Classic Wishbone slave front end producing register strobes
`timescale 1ns/1ps
`default_nettype none

module mso_wb_slave
    import mso_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [7:0]  rd_byte_i,
    output logic             ack_o,
    output logic [31:0]      dat_o,
    output logic             wr_en_o,
    output logic [7:0]       wr_byte_o,
    output logic             rd_latch_o
);

    logic        ack_r;
    logic [31:0] dat_r;
    logic        req;

    assign req        = cyc_i & stb_i;
    // Read data is sampled one cycle before ack so it stands with ack
    assign rd_latch_o = req & ~ack_r & ~we_i;
    // Writes land on the edge where the master samples ack
    assign wr_en_o    = req & ack_r & we_i & sel_i[0];
    assign wr_byte_o  = dat_i[7:0];
    assign ack_o      = ack_r;
    assign dat_o      = dat_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_r <= 32'h00000000;
        else if (rd_latch_o)
            dat_r <= {24'h000000, rd_byte_i};
    end

endmodule : mso_wb_slave

`default_nettype wire

// ### rtl/mso_win_dec.sv
// Address window decoder steering one window to RAM or program EPROM
`timescale 1ns/1ps
`default_nettype none

module mso_win_dec
#(
    parameter logic [15:0] WIN_LO = 16'h0000,
    parameter logic [15:0] WIN_HI = 16'h0000
)
(
    input  wire logic [15:0] addr_i,
    input  wire logic        map_ram_i,
    output logic             hit_o,
    output logic             ram_o
);

    assign hit_o = (addr_i >= WIN_LO) && (addr_i <= WIN_HI);
    assign ram_o = hit_o & map_ram_i;

endmodule : mso_win_dec

`default_nettype wire

// ### sim/mso_cfg_props.sv
// Port level checks for the option configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mso_regs.svh"

module mso_cfg_props
#(
    parameter logic BASE_STOP_EN = 1'b1,
    parameter logic BASE_WDOG_EN = 1'b0
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        ack_o,
    input  wire logic [7:0]  port_b_option_location_i,
    input  wire logic [7:0]  personality_option_location_i,
    input  wire logic [7:0]  port_b_ddr_i,
    input  wire logic [7:0]  port_b_pullup_interrupt_enables_o,
    input  wire logic [6:0]  port_d_ddr_i,
    input  wire logic [6:0]  port_d_out_en_o,
    input  wire logic        port_d_wire_or_i,
    input  wire logic        port_d_open_drain_o,
    input  wire logic [2:0]  spi_drive_req_i,
    input  wire logic [2:0]  spi_ddr_i,
    input  wire logic [2:0]  spi_out_en_o,
    input  wire logic        int_reset_req_i,
    input  wire logic        reset_pin_o,
    input  wire logic        reset_pin_oe_o,
    input  wire logic        irq_edge_level_o,
    input  wire logic        stop_en_o,
    input  wire logic        wdog_en_o,
    input  wire logic        compat_mode_o,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        ram_select_o,
    input  wire logic        eprom_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic in_win;
    assign in_win = (cpu_addr_i >= `MSO_LOW_WIN_LO
                     && cpu_addr_i <= `MSO_LOW_WIN_HI)
                    || (cpu_addr_i >= `MSO_HIGH_WIN_LO
                        && cpu_addr_i <= `MSO_HIGH_WIN_HI);

    // First edge after reset still shows reset values, hence the guards
    property p_pd_dir;
        !$past(rst_i) |-> port_d_out_en_o
            == (compat_mode_o ? 7'h00 : $past(port_d_ddr_i));
    endproperty
    a_pd_dir: assert property (p_pd_dir)
        else $error("port D direction enable wrong");
    property p_spi;
        !$past(rst_i) |-> spi_out_en_o == (compat_mode_o ?
            $past(spi_drive_req_i) : $past(spi_drive_req_i & spi_ddr_i));
    endproperty
    a_spi: assert property (p_spi)
        else $error("SPI output enable wrong");
    property p_odr;
        !$past(rst_i) |-> port_d_open_drain_o
            == ($past(port_d_wire_or_i) && !compat_mode_o);
    endproperty
    a_odr: assert property (p_odr)
        else $error("port D open drain wrong");
    property p_rst_pin;
        !$past(rst_i) |-> !reset_pin_o && reset_pin_oe_o
            == (!compat_mode_o && $past(int_reset_req_i));
    endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("reset pin drive wrong");
    property p_pb;
        !$past(rst_i) |-> port_b_pullup_interrupt_enables_o
            == (port_b_option_location_i & ~$past(port_b_ddr_i));
    endproperty
    a_pb: assert property (p_pb)
        else $error("port B pullup enables wrong");
    property p_core;
        !$past(rst_i) |->
            compat_mode_o == personality_option_location_i[0]
            && stop_en_o == (compat_mode_o ?
                personality_option_location_i[1] : BASE_STOP_EN)
            && wdog_en_o == (compat_mode_o ?
                personality_option_location_i[2] : BASE_WDOG_EN);
    endproperty
    a_core: assert property (p_core)
        else $error("core option outputs wrong");
    property p_irq_c;
        compat_mode_o && !$past(rst_i)
            |-> irq_edge_level_o == personality_option_location_i[3];
    endproperty
    a_irq_c: assert property (p_irq_c)
        else $error("sensitivity differs from option");
    property p_irq_once;
        !$past(rst_i) |-> !$rose(irq_edge_level_o);
    endproperty
    a_irq_once: assert property (p_irq_once)
        else $error("sensitivity rose after reset");
    property p_win_out;
        !$past(rst_i) && !$past(in_win)
            |-> !ram_select_o && !eprom_select_o;
    endproperty
    a_win_out: assert property (p_win_out)
        else $error("select active outside windows");
    property p_win_in;
        !$past(rst_i) && $past(in_win) |-> (ram_select_o ^ eprom_select_o)
            && (!compat_mode_o || eprom_select_o);
    endproperty
    a_win_in: assert property (p_win_in)
        else $error("window select wrong");
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus acknowledge timing wrong");
endmodule : mso_cfg_props
`default_nettype wire

// ### sim/mso_cfg_tb.sv
// Self-checking bench for the option configuration block
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end

module mso_cfg_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, wire_or = 1'b0, int_rst = 1'b0, locked;
    logic [15:0] adr_i = 16'h0000, cpu_addr_i = 16'h0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, r, dw;
    logic [7:0]  pb_opt = 8'h00, pers_opt = 8'h00, pb_ddr = 8'h00;
    logic [7:0]  sw_m, q, pb_en;
    logic [6:0]  pd_ddr = 7'h00, pd_oe;
    logic [2:0]  spi_req = 3'h0, spi_ddr = 3'h0, spi_oe;
    logic        ack_o, od, rpin, rpin_oe, irq, stop_en, wdog_en, compat;
    logic        ram_sel, eprom_sel;
    logic [15:0] corner [9] = '{16'h001F, 16'h0020, 16'h004F, 16'h0050,
        16'h00FF, 16'h0100, 16'h017F, 16'h0180, 16'h3FF0};
    int          n_errors = 0, checked = 0, seed = 32'hbd5c7e42;

    always #2.5 clk_i = ~clk_i;

    mso_cfg dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .ack_o(ack_o), .dat_o(dat_o), .port_b_option_location_i(pb_opt),
        .personality_option_location_i(pers_opt), .port_b_ddr_i(pb_ddr),
        .port_b_pullup_interrupt_enables_o(pb_en), .port_d_ddr_i(pd_ddr),
        .port_d_out_en_o(pd_oe), .port_d_wire_or_i(wire_or),
        .port_d_open_drain_o(od), .spi_drive_req_i(spi_req),
        .spi_ddr_i(spi_ddr), .spi_out_en_o(spi_oe),
        .int_reset_req_i(int_rst), .reset_pin_o(rpin),
        .reset_pin_oe_o(rpin_oe), .irq_edge_level_o(irq),
        .stop_en_o(stop_en), .wdog_en_o(wdog_en), .compat_mode_o(compat),
        .cpu_addr_i(cpu_addr_i), .ram_select_o(ram_sel),
        .eprom_select_o(eprom_sel));

    task results;
        $display("counts: checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // Holds the request until ack is sampled, then releases it
    task wb(input logic [15:0] a, input logic w, input logic [3:0] s,
            input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q  = dat_o[7:0];
        dw = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task sw_write(input logic [7:0] d, input logic [3:0] s);
        wb(16'h3FF4, 1'b1, s, d);
        if (!pers_opt[0] && s[0])
        begin
            sw_m[1:0] = d[1:0];
            if (!locked)
                sw_m[2] = d[2];
            locked = 1'b1;
        end
    endtask : sw_write

    function automatic logic [1:0] exp_win(input logic [15:0] a,
                                           input logic c, input logic [7:0] s);
        logic lo, hi, ram;
        lo = a >= 16'h0020 && a <= 16'h004F;
        hi = a >= 16'h0100 && a <= 16'h017F;
        ram = !c && ((lo && s[0]) || (hi && s[1]));
        return {ram, (lo || hi) && !ram};
    endfunction : exp_win

    task chk_pins;
        logic       c;
        logic [1:0] se;
        c = pers_opt[0];
        se = c ? {pers_opt[1], pers_opt[2]} : 2'b10;
        `CHK(pd_oe, c ? 7'h00 : pd_ddr)
        `CHK(spi_oe, c ? spi_req : spi_req & spi_ddr)
        `CHK(od, wire_or & !c)
        `CHK({rpin, rpin_oe}, {1'b0, int_rst & !c})
        `CHK(pb_en, pb_opt & ~pb_ddr)
        `CHK({ram_sel, eprom_sel}, exp_win(cpu_addr_i, c, sw_m))
        `CHK(irq, c ? pers_opt[3] : sw_m[2])
        `CHK({stop_en, wdog_en}, se)
    endtask : chk_pins

    task run_mode(input logic [7:0] p);
        logic [7:0] d;
        r = $random(seed);
        @(posedge clk_i);
        rst_i    <= 1'b1;
        pers_opt <= p;
        pb_opt   <= r[7:0];
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        sw_m = 8'h04;
        locked = 1'b0;
        wb(16'h3FF0, 1'b0, 4'hF, 8'h00);
        `CHK(dw, {24'h000000, pb_opt})
        wb(16'h3FF8, 1'b0, 4'hF, 8'h00);
        `CHK(q, {4'h0, p[3:0]})
        wb(16'h3FFC, 1'b0, 4'hF, 8'h00);
        `CHK(q[0], p[0])
        `CHK(compat, p[0])
        wb(16'h3FE0, 1'b0, 4'hF, 8'h00);
        `CHK(q, 8'h00)
        // Reset value of the software option before any write
        wb(16'h3FF4, 1'b0, 4'hF, 8'h00);
        `CHK(q, p[0] ? 8'h00 : 8'h04)
        `CHK(irq, p[0] ? p[3] : 1'b1)
        for (int i = 0; i < 30; i++)
        begin
            r = $random(seed);
            d = (i == 0) ? (r[7:0] & 8'hFB) : (i == 1) ? 8'h04 : r[7:0];
            sw_write(d, (i == 4) ? 4'hE : 4'hF);
            wb(16'h3FF4, 1'b0, 4'hF, 8'h00);
            `CHK(q, p[0] ? 8'h00 : {5'h00, sw_m[2:0]})
            @(posedge clk_i);
            pd_ddr  <= r[6:0];
            spi_req <= r[9:7];
            spi_ddr <= r[12:10];
            wire_or <= r[13];
            int_rst <= r[14];
            pb_ddr  <= r[22:15];
            cpu_addr_i <= (i < 9) ? corner[i] : {7'h00, r[31:23]};
            repeat (2) @(posedge clk_i);
            chk_pins();
        end
        $display("test personality %h done", p);
    endtask : run_mode

    initial
    begin
        run_mode(8'h0E);
        run_mode(8'h01);
        run_mode(8'h0F);
        run_mode(8'h00);
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        results();
    end
endmodule : mso_cfg_tb

bind mso_cfg mso_cfg_props #(.BASE_STOP_EN(BASE_STOP_EN),
    .BASE_WDOG_EN(BASE_WDOG_EN)) u_props (.*);
`default_nettype wire
